// *** rtl/tbl_loader.sv ***
// Purpose: boot loader for one tile, channel boot or secure otp boot
// Assumes: channel words arrive pre-assembled, one per valid cycle
// Notes:   the last channel image word is the crc; residue of the whole channel image is checked, the otp image is not
//
// Summary of operation
// - Channel boot claims endpoint 0 and first takes one word naming the acknowledge endpoint, null meaning none.
// - After that word the image with its crc and then an end token are accepted in that order.
// - On the end token an end token goes to the acknowledge endpoint, endpoint 0 is released, then execution starts if the crc residue is good.
// - Secure boot fetches its image from otp address 0 onward.
// - This tile picks its boot source alone from its own mode input I_SECURE_BOOT; the otp plays no part in the choice.
// - The otp is four sectors of 512 rows of 32 bits, 8 KB in all.
// - The security word is loaded from otp before anything runs.
// - The whole otp from row 0, the security word row included, is copied to sram and then run first.
// - Otp programming uses an address port of 16 bits at resource 0x100200, driven out as its low 16 bits 0x0200.
// - Reset I_RST is active high and asynchronous; the active low pin is sampled, and after its release the loader waits for pll lock then boots.
// - Booting starts once pll lock is seen; the 150 us window is only counted in wait_q, not enforced.
`timescale 1ns/1ns
`default_nettype none
module tbl_loader #(
   parameter int INIT_CYC = tbl_pkg::TBL_INIT_CYC
) (
   // clock, reset and boot mode
   input  wire logic                 I_REF_CLK,
   input  wire logic                 I_RST,
   input  wire logic                 I_RST_N_PIN,
   input  wire logic                 I_PLL_LOCK,
   input  wire logic                 I_SECURE_BOOT,
   // channel in and out
   input  wire tbl_pkg::tbl_chan_s   I_CHAN_RX,
   output logic                      O_CHAN_RX_READY,
   output tbl_pkg::tbl_chan_s        O_CHAN_TX,
   output logic [31:0]               O_CHAN_TX_DEST,
   input  wire logic                 I_CHAN_TX_READY,
   output logic                      O_CHAN0_CLAIMED,
   // otp read
   output tbl_pkg::tbl_otp_req_s     O_OTP_REQ,
   input  wire logic [31:0]          I_OTP_DATA,
   input  wire logic                 I_OTP_VALID,
   // otp programming port
   output logic [15:0]               O_OTP_PROG_ADDR_RES,
   // sram write and status
   output logic                      O_SRAM_WE,
   output logic [10:0]               O_SRAM_ADDR,
   output logic [31:0]               O_SRAM_DATA,
   output logic [31:0]               O_SECURITY,
   output logic                      O_BOOT_START,
   output logic                      O_JUMP,
   output logic                      O_BOOT_FAIL
);
   import tbl_pkg::*;

   typedef enum {S_RST, S_LOCK, S_SEC, S_ACK, S_IMG, S_TXEND, S_FREE, S_OTP, S_RUN, S_FAIL} tbl_st_e;

   tbl_st_e     st_q;
   tbl_st_e     st_d;
   logic [31:0] ack_q;
   logic [31:0] crc_q;
   logic [31:0] crc_nx;
   logic [10:0] idx_q;
   logic [31:0] sec_q;
   logic [31:0] wait_q;
   logic        rst_pin_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire rx_take  = I_CHAN_RX.valid && O_CHAN_RX_READY;
   wire rx_word  = rx_take && !I_CHAN_RX.ctrl;
   wire rx_end   = rx_take && I_CHAN_RX.ctrl && I_CHAN_RX.data[7:0] == TBL_TOKEN_END;
   wire ack_none = ack_q == TBL_NULL_CHANEND;
   wire crc_good = crc_q == TBL_CRC_RESIDUE;
   wire otp_last = idx_q == 11'(TBL_OTP_SECTORS * TBL_OTP_ROWS - 1);
   // array answers the address it sees, so present the row after the one just taken
   wire [10:0] otp_addr_nx = (st_q == S_SEC) ? TBL_OTP_IMG_ADDR :
                             (st_q == S_OTP && I_OTP_VALID) ? idx_q + 11'h1 : idx_q;

   tbl_crc32 u_crc (
      .i_crc  (crc_q),
      .i_word (I_CHAN_RX.data),
      .o_crc  (crc_nx)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         S_RST:   if (rst_pin_q) st_d = S_LOCK;
         S_LOCK:  if (I_PLL_LOCK) st_d = S_SEC;
         S_SEC:   if (I_OTP_VALID) st_d = I_SECURE_BOOT ? S_OTP : S_ACK;
         S_ACK:   if (rx_word) st_d = S_IMG;
         S_IMG:   if (rx_end) st_d = ack_none ? S_FREE : S_TXEND;
         S_TXEND: if (I_CHAN_TX_READY) st_d = S_FREE;
         S_FREE:  st_d = crc_good ? S_RUN : S_FAIL;
         S_OTP:   if (I_OTP_VALID && otp_last) st_d = S_RUN;
         S_RUN:   st_d = S_RUN;
         S_FAIL:  st_d = S_FAIL;
         default: st_d = S_RST;
      endcase
   end

   // ------------------------------------------------------------
   // state and data
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         st_q      <= S_RST;
         rst_pin_q <= 1'b0;
      end else begin
         st_q      <= st_d;
         rst_pin_q <= I_RST_N_PIN;
      end
   end

   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         ack_q <= 32'h0;
         crc_q <= 32'h0;
      end else if (st_q == S_ACK && rx_word) begin
         ack_q <= I_CHAN_RX.data;
         crc_q <= TBL_CRC_INIT;
      end else if (st_q == S_IMG && rx_word) begin
         crc_q <= crc_nx;
      end
   end

   // otp index: security word at row 0, image also read from row 0 on
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         idx_q <= 11'h0;
         sec_q <= 32'h0;
      end else if (st_q == S_SEC && I_OTP_VALID) begin
         sec_q <= I_OTP_DATA;
         idx_q <= TBL_OTP_IMG_ADDR;
      end else if (st_q == S_OTP && I_OTP_VALID) begin
         idx_q <= idx_q + 11'h1;
      end else if (st_q == S_IMG && rx_word) begin
         idx_q <= idx_q + 11'h1;
      end
   end

   // long count capped, a late lock still leaves booting pending
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         wait_q <= 32'h0;
      end else if (st_q == S_LOCK && wait_q < 32'(INIT_CYC)) begin
         wait_q <= wait_q + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CHAN_RX_READY     <= 1'b0;
         O_CHAN_TX           <= '0;
         O_CHAN_TX_DEST      <= 32'h0;
         O_CHAN0_CLAIMED     <= 1'b0;
         O_OTP_REQ           <= '0;
         O_OTP_PROG_ADDR_RES <= 16'h0;
         O_SRAM_WE           <= 1'b0;
         O_SRAM_ADDR         <= 11'h0;
         O_SRAM_DATA         <= 32'h0;
         O_SECURITY          <= 32'h0;
         O_BOOT_START        <= 1'b0;
         O_JUMP              <= 1'b0;
         O_BOOT_FAIL         <= 1'b0;
      end else begin
         O_CHAN0_CLAIMED     <= st_d == S_ACK || st_d == S_IMG || st_d == S_TXEND;
         O_CHAN_RX_READY     <= st_d == S_ACK || st_d == S_IMG;
         O_CHAN_TX.valid     <= st_d == S_TXEND;
         O_CHAN_TX.ctrl      <= st_d == S_TXEND;
         O_CHAN_TX.data      <= {24'h0, TBL_TOKEN_END};
         O_CHAN_TX_DEST      <= ack_q;
         O_OTP_REQ.req       <= st_d == S_SEC || st_d == S_OTP;
         O_OTP_REQ.addr      <= (st_d == S_SEC) ? TBL_OTP_SEC_ADDR : otp_addr_nx;
         O_OTP_PROG_ADDR_RES <= TBL_OTP_ADDR_RES[15:0];
         O_SRAM_WE           <= (st_q == S_IMG && rx_word) || (st_q == S_OTP && I_OTP_VALID);
         O_SRAM_ADDR         <= idx_q;
         O_SRAM_DATA         <= (st_q == S_OTP) ? I_OTP_DATA : I_CHAN_RX.data;
         O_SECURITY          <= sec_q;
         O_BOOT_START        <= st_q != S_RST && st_q != S_LOCK;
         O_JUMP              <= st_q == S_RUN;
         O_BOOT_FAIL         <= st_q == S_FAIL;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RST);

   a_ack_first: assert property ((st_q == S_ACK && rx_word) |=> st_q == S_IMG && ack_q == $past(I_CHAN_RX.data))
      else $error("ack word not captured");
   a_end_order: assert property ((st_q == S_IMG && rx_end && !ack_none) |=> st_q == S_TXEND)
      else $error("end token not followed by ack send");
   a_tx_end_tok: assert property ((st_q == S_TXEND) |-> O_CHAN_TX.valid && O_CHAN_TX.ctrl && O_CHAN_TX_DEST == ack_q)
      else $error("end token not sent to ack endpoint");
   a_free_chan: assert property ((st_q == S_RUN) |-> !O_CHAN0_CLAIMED)
      else $error("endpoint 0 held while running");
   a_sec_first: assert property ((st_q == S_SEC && I_OTP_VALID) |=> O_SECURITY == 32'h0 ##1 O_SECURITY == $past(I_OTP_DATA, 2))
      else $error("security word not loaded");
   a_otp_from0: assert property ((st_q == S_SEC && I_OTP_VALID && I_SECURE_BOOT) |=> idx_q == 11'h0 && O_OTP_REQ.addr == TBL_OTP_IMG_ADDR)
      else $error("otp image not from address 0");
   a_boot_prompt: assert property ((st_q == S_LOCK && I_PLL_LOCK) |=> ##1 O_BOOT_START)
      else $error("boot start not raised after lock");
   a_lock_wait: assert property ((st_q == S_LOCK && !I_PLL_LOCK) |=> st_q == S_LOCK)
      else $error("boot began before pll lock");
   a_no_early_jump: assert property ((st_q == S_IMG) |-> !O_JUMP ##1 !O_JUMP)
      else $error("jump before end token");
   a_crc_fail: assert property ((st_q == S_FREE && !crc_good) |=> st_q == S_FAIL ##1 O_BOOT_FAIL)
      else $error("crc mismatch not flagged");

   c_chan_boot: cover property (st_q == S_FREE && crc_good);
   c_otp_boot:  cover property (st_q == S_OTP ##1 st_q == S_RUN);
   c_null_ack:  cover property (st_q == S_IMG && rx_end && ack_none);
   c_fail:      cover property (O_BOOT_FAIL);
   // lock slower than the boot window, the only place the wait count is watched
   c_late_lock: cover property (st_q == S_LOCK && wait_q == 32'(INIT_CYC));
endmodule
`default_nettype wire

// *** rtl/tbl_pkg.sv ***
// Purpose: shared constants and carriers for the tile boot loader
// Assumes: 250 MHz core clock
// Notes:   times kept in their own units, cycle counts derived here
package tbl_pkg;
   // ------------------------------------------------------------
   // channel and token values
   // ------------------------------------------------------------
   localparam logic [31:0] TBL_NULL_CHANEND  = 32'h0000ff02;
   localparam logic [7:0]  TBL_TOKEN_END     = 8'h01;
   localparam logic [7:0]  TBL_BOOT_CHANEND  = 8'h00;
   localparam logic [31:0] TBL_CRC_INIT      = 32'hffffffff;
   localparam logic [31:0] TBL_CRC_POLY      = 32'hedb88320;
   localparam logic [31:0] TBL_CRC_RESIDUE   = 32'hdebb20e3;
   // ------------------------------------------------------------
   // one-time-programmable memory layout
   // ------------------------------------------------------------
   localparam int          TBL_OTP_SECTORS   = 4;
   localparam int          TBL_OTP_ROWS      = 512;
   localparam int          TBL_OTP_WIDTH     = 32;
   localparam int          TBL_OTP_AW        = 11;
   localparam logic [10:0] TBL_OTP_SEC_ADDR  = 11'h000;
   localparam logic [10:0] TBL_OTP_IMG_ADDR  = 11'h000;
   localparam logic [23:0] TBL_OTP_ADDR_RES  = 24'h100200;
   localparam int          TBL_OTP_PORT_W    = 16;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          TBL_CLK_MHZ       = 250;
   localparam int          TBL_RST_MIN_NS    = 100;
   localparam int          TBL_INIT_MAX_US   = 150;
   localparam int          TBL_INIT_CYC      = TBL_INIT_MAX_US * TBL_CLK_MHZ;
   localparam int          TBL_RST_MIN_CYC   = (TBL_RST_MIN_NS * TBL_CLK_MHZ + 999) / 1000;
   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        ctrl;
      logic [31:0] data;
   } tbl_chan_s;
   typedef struct packed {
      logic        req;
      logic [10:0] addr;
   } tbl_otp_req_s;
endpackage

// *** rtl/tbl_crc32.sv ***
// Purpose: one-word crc32 step over the received boot image
// Assumes: reflected polynomial, word taken low bit first
// Notes:   pure combinational, the loader holds the running value
`timescale 1ns/1ns
`default_nettype none
module tbl_crc32 (
   // running value and new word
   input  wire logic [31:0] i_crc,
   input  wire logic [31:0] i_word,
   // next value
   output logic      [31:0] o_crc
);
   import tbl_pkg::*;
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
      logic [31:0] r;
      r = c ^ w;
      for (int k = 0; k < 32; k++) begin
         r = r[0] ? ((r >> 1) ^ TBL_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
   assign o_crc = crc_step(i_crc, i_word);
endmodule
`default_nettype wire

// *** verif/tbl_host_model.sv ***
// Purpose: boot host that feeds the loader over the channel network
// Assumes: image words are placed in img by the bench before send
// Notes:   random gaps between words and random stalls on the ack token
`timescale 1ns/1ns
`default_nettype none
module tbl_host_model
   import tbl_pkg::*;
(
   // clock and flow control
   input  wire logic i_clk,
   input  wire logic i_rx_ready,
   // channel toward the loader
   output tbl_chan_s o_rx,
   output logic      o_tx_ready
);
   // ------------------------------------------------------------
   // sender
   // ------------------------------------------------------------
   logic [31:0] img [0:15];
   logic        end_sent;

   initial begin
      o_rx = '0;
      o_tx_ready = 1'b0;
      end_sent = 1'b0;
   end

   // stalls the returned token now and then
   always @(posedge i_clk) begin
      o_tx_ready <= ($urandom_range(3) != 0);
   end

   // held until taken; a released line shows the inverse so no stale word passes
   task automatic put(input logic ctrl, input logic [31:0] w);
      int gap;
      gap = $urandom_range(2);
      o_rx <= {1'b1, ctrl, w};
      do @(posedge i_clk); while (i_rx_ready !== 1'b1);
      if (gap != 0) begin
         o_rx <= {1'b0, 1'b0, ~w};
         repeat (gap) @(posedge i_clk);
      end
   endtask

   task automatic send(input logic [31:0] ack, input int n);
      put(1'b0, ack);
      for (int i = 0; i <= n; i++) begin
         put(1'b0, img[i]);
      end
      put(1'b1, {24'h0, TBL_TOKEN_END});
      end_sent = 1'b1;
      o_rx <= {1'b0, 1'b0, 32'hfffffffe};
   endtask
endmodule
`default_nettype wire

// *** verif/tbl_loader_tb.sv ***
// Purpose: self-checking bench for the tile boot loader
// Assumes: INIT_CYC shortened to 16, otp rows answered in two cycles
// Notes:   good channel boot, bad crc with null ack, then secure boot
`timescale 1ns/1ns
`default_nettype none
module tbl_loader_tb;
   import tbl_pkg::*;
   // ------------------------------------------------------------
   // bench
   // ------------------------------------------------------------
   logic         clk = 1'b0, rst = 1'b1, pin = 1'b0, lock = 1'b0, secb = 1'b0;
   logic         rx_ready, tx_ready, claimed, we, jump, fail, bstart;
   logic         otp_valid = 1'b0;
   logic [31:0]  otp_data = 32'h0, otp_base = 32'h0, ack_exp, dest, sec, sram_d;
   logic [15:0]  prog;
   logic [10:0]  sram_a;
   tbl_chan_s    rx, tx;
   tbl_otp_req_s oreq;
   logic [31:0]  exp_q [$];
   int           errors = 0, comparisons = 0, cyc = 0, tx_cnt = 0, wr_idx = 0;

   always #2 clk = ~clk;

   tbl_loader #(.INIT_CYC(16)) dut (
      .I_REF_CLK(clk), .I_RST(rst), .I_RST_N_PIN(pin), .I_PLL_LOCK(lock),
      .I_SECURE_BOOT(secb), .I_CHAN_RX(rx), .O_CHAN_RX_READY(rx_ready),
      .O_CHAN_TX(tx), .O_CHAN_TX_DEST(dest), .I_CHAN_TX_READY(tx_ready),
      .O_CHAN0_CLAIMED(claimed), .O_OTP_REQ(oreq), .I_OTP_DATA(otp_data),
      .I_OTP_VALID(otp_valid), .O_OTP_PROG_ADDR_RES(prog), .O_SRAM_WE(we),
      .O_SRAM_ADDR(sram_a), .O_SRAM_DATA(sram_d), .O_SECURITY(sec),
      .O_BOOT_START(bstart), .O_JUMP(jump), .O_BOOT_FAIL(fail));

   tbl_host_model host (.i_clk(clk), .i_rx_ready(rx_ready), .o_rx(rx), .o_tx_ready(tx_ready));

   // otp array: one row per request, data tagged with its row
   always @(posedge clk) begin
      otp_valid <= oreq.req & ~otp_valid;
      otp_data  <= (oreq.req & ~otp_valid) ? otp_base ^ {21'h0, oreq.addr} : ~otp_data;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
      logic [31:0] r;
      r = c ^ w;
      for (int b = 0; b < 32; b++) r = r[0] ? (r >> 1) ^ TBL_CRC_POLY : r >> 1;
      return r;
   endfunction

   // scoreboard: every sram write takes the oldest note
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (we === 1'b1) begin
         chk(32'(sram_a), wr_idx);
         wr_idx++;
         if (exp_q.size() == 0) chk(1'b1, 1'b0);
         else chk(sram_d, exp_q.pop_front());
      end
      if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
         tx_cnt++;
         chk(dest, ack_exp);
         chk({tx.ctrl, tx.data[7:0]}, {1'b1, TBL_TOKEN_END});
      end
      if (jump === 1'b1) chk(host.end_sent | secb, 1'b1);
      if (cyc == 12000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic run(input logic sm, input int n, input logic [31:0] ack, input logic bad);
      logic [31:0] c;
      int          k;
      c = TBL_CRC_INIT;
      otp_base = $urandom;
      exp_q.delete();
      tx_cnt = 0;
      wr_idx = 0;
      ack_exp = ack;
      if (sm) begin
         for (k = 0; k < TBL_OTP_SECTORS * TBL_OTP_ROWS; k++) exp_q.push_back(otp_base ^ k);
      end else begin
         for (k = 0; k < n; k++) begin
            host.img[k] = $urandom;
            c = crc_step(c, host.img[k]);
            exp_q.push_back(host.img[k]);
         end
         host.img[n] = bad ? c : ~c;
         exp_q.push_back(host.img[n]);
      end
      @(posedge clk);
      rst <= 1'b1;
      pin <= 1'b0;
      lock <= 1'b0;
      secb <= sm;
      repeat (12) @(posedge clk);
      // cleared only once the previous jump level is gone
      host.end_sent = 1'b0;
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(bstart, 1'b0);
      chk(prog, 16'h0200);
      repeat (TBL_RST_MIN_CYC) @(posedge clk);
      pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(oreq.req, 1'b0);
      @(posedge clk);
      lock <= 1'b1;
      for (k = 0; k < 40 && oreq.req !== 1'b1; k++) begin @(posedge clk); #1; end
      chk(oreq.addr, TBL_OTP_SEC_ADDR);
      for (k = 0; k < 40 && otp_valid !== 1'b1; k++) begin @(posedge clk); #1; end
      repeat (3) @(posedge clk);
      #1 chk(sec, otp_base);
      for (k = 0; k < 8 && bstart !== 1'b1; k++) begin @(posedge clk); #1; end
      chk(bstart, 1'b1);
      if (!sm) begin
         for (k = 0; k < 20 && rx_ready !== 1'b1; k++) begin @(posedge clk); #1; end
         chk(claimed, 1'b1);
         @(posedge clk);
         host.send(ack, n);
      end
      for (k = 0; k < 6000 && jump !== 1'b1 && fail !== 1'b1; k++) begin @(posedge clk); #1; end
      repeat (4) @(posedge clk);
      #1 chk(fail, bad);
      if (!bad) chk(jump, 1'b1);
      chk(claimed, 1'b0);
      chk(tx_cnt, !sm && ack != TBL_NULL_CHANEND);
      chk(exp_q.size(), 0);
   endtask

   initial begin
      void'($urandom(46));
      run(1'b0, 8, $urandom & 32'hfffffff0, 1'b0);
      run(1'b0, 5, TBL_NULL_CHANEND, 1'b1);
      run(1'b1, 0, 32'h0, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
